// File: design/iface_ctrl_pkg.sv
package iface_ctrl_pkg;
	// ----------------------------------------
	// register addresses
	// ----------------------------------------
	localparam logic [5:0] ADDR_WRITE = 6'h07;
	localparam logic [5:0] ADDR_SET   = 6'h08;
	localparam logic [5:0] ADDR_CLEAR = 6'h09;
	localparam logic [7:0] RESET_VAL  = 8'h00;
	localparam logic [7:0] ZERO_BYTE  = 8'h00;
	localparam logic [7:0] ALL_ONES   = 8'hFF;
	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int BIT_PROTECT_DIS = 7;
	localparam int BIT_PASSTHROUGH = 6;
	localparam int BIT_COMPLEMENT  = 5;
	localparam int BIT_CLK_KEEP    = 3;
	localparam int BIT_THREE_WIRE  = 1;
	localparam int BIT_SIX_WIRE    = 0;
	// used bits; reserved 4 and 2 store but steer nothing
	localparam logic [7:0] USED_MASK = 8'hEB;
	typedef enum logic [2:0] {
		MODE_PARALLEL = 3'h1,
		MODE_SIX      = 3'h2,
		MODE_THREE    = 3'h4
	} iface_mode_t;
endpackage : iface_ctrl_pkg

// File: design/iface_reg_file.sv
`timescale 1ns/1ps
// ----------------------------------------
// control byte with write/set/clear aliases
// ----------------------------------------
module iface_reg_file (
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	input  wire logic       wr_en,
	input  wire logic [5:0] wr_addr,
	input  wire logic [7:0] wr_data,
	input  wire logic       three_exit,
	input  wire logic       six_exit,
	output logic      [7:0] ctrl_reg
);
	logic [7:0] ctrl_next;

	always_comb begin
		ctrl_next = ctrl_reg;
		if (wr_en) begin
			unique case (wr_addr)
				iface_ctrl_pkg::ADDR_WRITE: ctrl_next = wr_data;
				iface_ctrl_pkg::ADDR_SET:   ctrl_next = ctrl_reg | wr_data;
				iface_ctrl_pkg::ADDR_CLEAR: ctrl_next = ctrl_reg & ~wr_data;
				default:                    ctrl_next = ctrl_reg;
			endcase
		end
		// hardware exit clear wins over a write in the same cycle
		if (three_exit)
			ctrl_next[iface_ctrl_pkg::BIT_THREE_WIRE] = 1'b0;
		if (six_exit)
			ctrl_next[iface_ctrl_pkg::BIT_SIX_WIRE] = 1'b0;
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			ctrl_reg <= iface_ctrl_pkg::RESET_VAL;
		else
			ctrl_reg <= ctrl_next;
	end

	a_set_alias: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(wr_en && wr_addr == iface_ctrl_pkg::ADDR_SET && !three_exit && !six_exit)
		|=> ctrl_reg == ($past(ctrl_reg) | $past(wr_data)))
		else $error("set alias did not OR the written bits");
	a_clear_alias: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(wr_en && wr_addr == iface_ctrl_pkg::ADDR_CLEAR)
		|=> (ctrl_reg & $past(wr_data)) == iface_ctrl_pkg::ZERO_BYTE)
		else $error("clear alias left a written bit set");
	a_plain_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(wr_en && wr_addr == iface_ctrl_pkg::ADDR_WRITE && !three_exit && !six_exit)
		|=> ctrl_reg == $past(wr_data))
		else $error("plain write not stored");
	a_three_exit: assert property (@(posedge clk_sys) disable iff (!rst_n)
		three_exit |=> !ctrl_reg[iface_ctrl_pkg::BIT_THREE_WIRE])
		else $error("3-wire bit not cleared on exit");
	a_six_exit: assert property (@(posedge clk_sys) disable iff (!rst_n)
		six_exit |=> !ctrl_reg[iface_ctrl_pkg::BIT_SIX_WIRE])
		else $error("6-wire bit not cleared on exit");
endmodule : iface_reg_file

// File: design/fault_indicator.sv
`timescale 1ns/1ps
// ----------------------------------------
// overcurrent indicator conditioning
// ----------------------------------------
module fault_indicator (
	input  wire logic clk_sys,
	input  wire logic rst_n,
	input  wire logic overcurrent_fault_in,
	input  wire logic vbus_valid_comparator,
	input  wire logic complement_en,
	input  wire logic passthrough_en,
	output logic      vbus_indicator_reg
);
	logic complement_out;
	logic vbus_indicator_next;

	always_comb begin
		complement_out      = overcurrent_fault_in ^ complement_en;
		vbus_indicator_next = passthrough_en ? complement_out
			: (complement_out & vbus_valid_comparator);
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			vbus_indicator_reg <= 1'b0;
		else
			vbus_indicator_reg <= vbus_indicator_next;
	end

	a_gated_ind: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(!passthrough_en && !vbus_valid_comparator) |=> !vbus_indicator_reg)
		else $error("indicator not gated by comparator");
	a_invert_ind: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(passthrough_en && complement_en) |=> vbus_indicator_reg != $past(overcurrent_fault_in))
		else $error("indicator not inverted");
endmodule : fault_indicator

// File: design/iface_control.sv
`timescale 1ns/1ps
module iface_control (
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	input  wire logic       reg_wr_en,
	input  wire logic [5:0] reg_addr,
	input  wire logic [7:0] reg_wr_data,
	output logic      [7:0] reg_rd_data,
	output logic            reg_rd_hit,
	input  wire logic       low_power_n,
	input  wire logic       serial_exit,
	input  wire logic       stop_in,
	input  wire logic       stop_driven,
	input  wire logic       overcurrent_fault_in,
	input  wire logic       vbus_valid_comparator,
	output logic            stop_pullup_en,
	output logic            data_pulldown_en,
	output logic            link_released,
	output logic            clock_powered,
	output logic      [2:0] iface_mode,
	output logic            vbus_indicator
);
	logic [7:0] ctrl_reg;
	logic       protect_on;
	logic       three_exit;
	logic       six_exit;
	logic       serial_active;
	logic       release_reg;
	logic       release_next;
	logic       pulldown_reg;
	logic       pulldown_next;
	iface_ctrl_pkg::iface_mode_t mode_reg;
	iface_ctrl_pkg::iface_mode_t mode_next;

	// ----------------------------------------
	// register file
	// ----------------------------------------
	assign three_exit = serial_exit && (mode_reg == iface_ctrl_pkg::MODE_THREE);
	assign six_exit   = serial_exit && (mode_reg == iface_ctrl_pkg::MODE_SIX);

	iface_reg_file u_regs (
		.clk_sys   (clk_sys),
		.rst_n     (rst_n),
		.wr_en     (reg_wr_en),
		.wr_addr   (reg_addr),
		.wr_data   (reg_wr_data),
		.three_exit(three_exit),
		.six_exit  (six_exit),
		.ctrl_reg  (ctrl_reg)
	);

	// all three aliases read the same byte
	always_comb begin
		reg_rd_hit  = (reg_addr == iface_ctrl_pkg::ADDR_WRITE)
			|| (reg_addr == iface_ctrl_pkg::ADDR_SET)
			|| (reg_addr == iface_ctrl_pkg::ADDR_CLEAR);
		reg_rd_data = reg_rd_hit ? ctrl_reg : iface_ctrl_pkg::ZERO_BYTE;
	end

	// ----------------------------------------
	// interface mode
	// ----------------------------------------
	// six-wire has priority if the link breaks the one-field rule
	always_comb begin
		if (ctrl_reg[iface_ctrl_pkg::BIT_SIX_WIRE])
			mode_next = iface_ctrl_pkg::MODE_SIX;
		else if (ctrl_reg[iface_ctrl_pkg::BIT_THREE_WIRE])
			mode_next = iface_ctrl_pkg::MODE_THREE;
		else
			mode_next = iface_ctrl_pkg::MODE_PARALLEL;
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			mode_reg <= iface_ctrl_pkg::MODE_PARALLEL;
		else
			mode_reg <= mode_next;
	end

	assign iface_mode    = mode_reg;
	assign serial_active = (mode_reg != iface_ctrl_pkg::MODE_PARALLEL);
	// suspend itself is owned elsewhere; here it only qualifies the clock keep
	assign clock_powered = !serial_active
		|| (low_power_n && ctrl_reg[iface_ctrl_pkg::BIT_CLK_KEEP]);

	// ----------------------------------------
	// interface protection
	// ----------------------------------------
	assign protect_on = !ctrl_reg[iface_ctrl_pkg::BIT_PROTECT_DIS];

	always_comb begin
		release_next  = protect_on && !stop_driven;
		pulldown_next = protect_on && stop_in && !stop_driven;
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			release_reg  <= 1'b0;
			pulldown_reg <= 1'b0;
		end else begin
			release_reg  <= release_next;
			pulldown_reg <= pulldown_next;
		end
	end

	assign stop_pullup_en   = protect_on;
	assign data_pulldown_en = pulldown_reg && protect_on;
	assign link_released    = release_reg;

	// ----------------------------------------
	// fault indicator
	// ----------------------------------------
	fault_indicator u_fault (
		.clk_sys              (clk_sys),
		.rst_n                (rst_n),
		.overcurrent_fault_in (overcurrent_fault_in),
		.vbus_valid_comparator(vbus_valid_comparator),
		.complement_en        (ctrl_reg[iface_ctrl_pkg::BIT_COMPLEMENT]),
		.passthrough_en       (ctrl_reg[iface_ctrl_pkg::BIT_PASSTHROUGH]),
		.vbus_indicator_reg   (vbus_indicator)
	);

	// ----------------------------------------
	// checks
	// ----------------------------------------
	sequence s_write_disable;
		reg_wr_en && reg_addr == iface_ctrl_pkg::ADDR_SET
			&& reg_wr_data[iface_ctrl_pkg::BIT_PROTECT_DIS];
	endsequence
	sequence s_pulls_off;
		!stop_pullup_en && !data_pulldown_en;
	endsequence

	a_protect_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
		s_write_disable |=> s_pulls_off)
		else $error("pulls stay on with protection disabled");
	a_pulldown_on: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(protect_on && stop_in && !stop_driven) ##1 protect_on |-> data_pulldown_en)
		else $error("data pull-downs missing on floating stop");
	a_release_seen: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(protect_on && !stop_driven) |=> link_released)
		else $error("link release not detected");
	a_mode_three: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(ctrl_reg == 8'h02) |=> iface_mode == iface_ctrl_pkg::MODE_THREE)
		else $error("3-wire mode not entered");
	a_mode_six: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ctrl_reg[iface_ctrl_pkg::BIT_SIX_WIRE] |=> iface_mode == iface_ctrl_pkg::MODE_SIX)
		else $error("6-wire mode not entered");
	a_mode_parallel: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(ctrl_reg & 8'h03) == iface_ctrl_pkg::ZERO_BYTE
		|=> iface_mode == iface_ctrl_pkg::MODE_PARALLEL)
		else $error("parallel mode not restored");
	a_clock_gate: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(serial_active && !low_power_n) |-> !clock_powered)
		else $error("clock kept powered while suspended");
	a_clock_keep: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(serial_active && low_power_n) |-> clock_powered == ctrl_reg[iface_ctrl_pkg::BIT_CLK_KEEP])
		else $error("clock keep bit not honoured");
	a_reserved_inert: assert property (@(posedge clk_sys) disable iff (!rst_n)
		// a write at this edge may flip the protect bit, so only idle cycles qualify
		!reg_wr_en && $stable(ctrl_reg & iface_ctrl_pkg::USED_MASK)
		&& $stable(stop_in) && $stable(stop_driven)
		|=> $stable(data_pulldown_en))
		else $error("reserved bits changed behaviour");
endmodule : iface_control

// File: sim/link_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// link controller: register writes, stop line
// ----------------------------------------
module link_model (
	input  wire logic       clk_sys,
	input  wire logic       pull_up,
	output logic            reg_wr_en,
	output logic      [5:0] reg_addr,
	output logic      [7:0] reg_wr_data,
	output logic            stop_in,
	output logic            stop_driven
);
	initial begin
		reg_wr_en   = 1'b0;
		reg_addr    = 6'h07;
		reg_wr_data = 8'h00;
		stop_in     = 1'b0;
		stop_driven = 1'b1;
	end
	// one bus step just after the edge; a strobe lasts one cycle
	task automatic put(input logic en, input logic [5:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		#1;
		reg_wr_en   = en;
		reg_addr    = a;
		reg_wr_data = d;
	endtask : put
	task automatic write(input logic [5:0] a, input logic [7:0] d);
		if (d[1] && d[0]) d[1] = 1'b0;
		put(1'b1, a, d);
		put(1'b0, a, ~d);
	endtask : write
	// a released line floats to the pull-up, or flips when nothing holds it
	task automatic drive_stop(input logic lvl, input logic drv);
		@(posedge clk_sys);
		#1;
		stop_driven = drv;
		stop_in     = drv ? lvl : (pull_up ? 1'b1 : ~stop_in);
	endtask : drive_stop
endmodule : link_model

// File: sim/ulpi_phy_interface_control_tb_top.sv
`timescale 1ns/1ps
module ulpi_phy_interface_control_tb_top;
	logic       clk_sys = 1'b0;
	logic       rst_n, lp, sexit, fault, vv, wen, pu, pd, rel, hit, ckp, ind, sin, sdrv;
	logic [5:0] addr;
	logic [7:0] wd, rd, exp, d;
	logic [2:0] mode;
	int         miscompares, total_checks;
	always #5 clk_sys = ~clk_sys;
	link_model link_model_i (.clk_sys(clk_sys), .pull_up(pu), .reg_wr_en(wen), .reg_addr(addr),
		.reg_wr_data(wd), .stop_in(sin), .stop_driven(sdrv));
	iface_control iface_control_i (.clk_sys(clk_sys), .rst_n(rst_n), .reg_wr_en(wen),
		.reg_addr(addr), .reg_wr_data(wd), .reg_rd_data(rd), .reg_rd_hit(hit),
		.low_power_n(lp), .serial_exit(sexit), .stop_in(sin), .stop_driven(sdrv),
		.overcurrent_fault_in(fault), .vbus_valid_comparator(vv), .stop_pullup_en(pu),
		.data_pulldown_en(pd), .link_released(rel), .clock_powered(ckp), .iface_mode(mode),
		.vbus_indicator(ind));
	function automatic logic [7:0] nxt(input logic [7:0] c, input logic [5:0] a,
		input logic [7:0] v);
		case (a)
			6'h07: return v;
			6'h08: return c | v;
			6'h09: return c & ~v;
			default: return c;
		endcase
	endfunction : nxt
	function automatic logic ind_exp(input logic f, input logic [7:0] c);
		return (f ^ c[5]) & (c[6] | vv);
	endfunction : ind_exp
	task automatic chk(input logic [15:0] got, input logic [15:0] want);
		total_checks++;
		if (got !== want) begin
			miscompares++;
			$display("Error at %0t: got %0h expected %0h", $time, got, want);
		end
	endtask : chk
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : report_and_stop
	initial begin
		#1ms;
		miscompares++;
		report_and_stop();
	end
	initial begin
		{rst_n, sexit, fault, vv, miscompares, total_checks} = '0;
		lp  = 1'b1;
		exp = 8'h00;
		void'($urandom(64340));
		repeat (4) @(posedge clk_sys);
		#1 rst_n = 1'b1;
		chk(rd, 8'h00);
		chk({pu, pd, ckp, mode}, 6'h29);
		// random traffic over all aliases plus unmapped neighbours
		for (int i = 0; i < 30; i++) begin
			{fault, vv} = 2'($urandom);
			d = 8'($urandom) & 8'hFC;
			link_model_i.write(6'h06 + 6'($urandom_range(4)), d);
			exp = nxt(exp, addr, d);
			// the indicator is registered: it shows the new control byte one edge later
			@(posedge clk_sys);
			#1;
			chk(ind, ind_exp(fault, exp));
			chk(pu, !exp[7]);
			chk(ckp, 1'b1);
			for (int k = 7; k <= 10; k++) begin
				link_model_i.put(1'b0, 6'(k), 8'h00);
				#1 chk({hit, rd}, k < 10 ? {1'b1, exp} : 9'h000);
			end
		end
		// each serial mode, with and without clock keep, then exit
		for (int i = 0; i < 4; i++) begin
			exp = {4'h0, i[1], 1'b0, i[0] ? 2'b01 : 2'b10};
			link_model_i.write(6'h07, exp);
			// mode register follows the control byte one edge later
			@(posedge clk_sys);
			#1;
			chk(mode, i[0] ? 3'h2 : 3'h4);
			lp = 1'($urandom);
			#1 chk(ckp, lp & i[1]);
			link_model_i.put(1'b0, 6'h07, 8'h00);
			sexit = 1'b1;
			link_model_i.put(1'b0, 6'h07, 8'h00);
			sexit = 1'b0;
			chk(rd, exp & 8'hFC);
			link_model_i.put(1'b0, 6'h07, 8'h00);
			chk({mode, ckp}, 4'h3);
		end
		// link lets go of stop with protection on, then protection off
		link_model_i.drive_stop(1'b0, 1'b0);
		link_model_i.put(1'b0, 6'h07, 8'h00);
		link_model_i.put(1'b0, 6'h07, 8'h00);
		chk({pd, rel}, 2'b11);
		link_model_i.write(6'h08, 8'h80);
		chk({pd, pu}, 2'b00);
		link_model_i.drive_stop(1'b0, 1'b1);
		report_and_stop();
	end
endmodule : ulpi_phy_interface_control_tb_top
